/* hce_pkg.sv */
// Constants and types for the horizontal clock edge position bank
package hce_pkg;
	localparam int unsigned hce_addr_w = 8;
	localparam int unsigned hce_data_w = 32;
	localparam int unsigned hce_pos_w = 6;
	localparam int unsigned hce_width_w = 4;

	// Register offsets
	localparam logic [7:0] hce_off_clk_a_edge = 8'h30;
	localparam logic [7:0] hce_off_clk_b_edge = 8'h31;
	localparam logic [7:0] hce_off_last_edge = 8'h32;
	localparam logic [7:0] hce_off_phase_one_edge = 8'h33;
	localparam logic [7:0] hce_off_reset_gate_edge = 8'h34;
	localparam logic [7:0] hce_off_blank_ctrl = 8'h35;

	// Edge position register fields
	localparam int unsigned hce_rise_lsb = 0;
	localparam int unsigned hce_fall_lsb = 8;
	localparam int unsigned hce_test_bit = 16;
	localparam int unsigned hce_edge_reg_w = 17;

	// Edge position reset values
	localparam logic [5:0] hce_rise_rst = 6'h00;
	localparam logic [5:0] hce_fall_rst = 6'h20;
	localparam logic [5:0] hce_rg_fall_rst = 6'h10;
	localparam logic hce_test_rst = 1'h1;

	// Blanking control register fields
	localparam int unsigned hce_resample_a_bit = 0;
	localparam int unsigned hce_resample_b_bit = 1;
	localparam int unsigned hce_resample_last_bit = 2;
	localparam int unsigned hce_resample_three_bit = 3;
	localparam int unsigned hce_width_lsb = 4;
	localparam int unsigned hce_last_blank_en_bit = 9;
	localparam int unsigned hce_extra_a_bit = 20;
	localparam int unsigned hce_extra_b_bit = 21;
	localparam int unsigned hce_extra_last_bit = 22;
	localparam int unsigned hce_extra_three_bit = 23;
	localparam int unsigned hce_ctrl_reg_w = 24;
	localparam logic [23:0] hce_ctrl_rst = 24'h000000;

	// Horizontal output configuration codes
	localparam logic [4:0] hce_cfg_mode_one = 5'h01;
	localparam logic [4:0] hce_cfg_mode_two = 5'h02;
	localparam logic [4:0] hce_cfg_mode_three = 5'h04;
	localparam logic [4:0] hce_cfg_three_phase = 5'h10;

	typedef enum logic [1:0] {
		hce_mode_one = 2'h0,
		hce_mode_two = 2'h1,
		hce_mode_three = 2'h3,
		hce_three_phase = 2'h2
	} hce_mode_e;
endpackage

/* hce_edge_gen.sv */
// Registered clock level from rising and falling edge positions
`timescale 1ns/1ps
module hce_edge_gen (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Position within the pixel period
	input wire logic [hce_pkg::hce_pos_w-1:0] phase_pos,
	// Edge positions
	input wire logic [hce_pkg::hce_pos_w-1:0] rise_pos,
	input wire logic [hce_pkg::hce_pos_w-1:0] fall_pos,
	// Clock level
	output logic level
);
	import hce_pkg::*;

	logic next_level;

	always_comb begin
		next_level = level;
		if (phase_pos == rise_pos && rise_pos != fall_pos) begin
			next_level = 1'b1;
		end else if (phase_pos == fall_pos) begin
			next_level = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			level <= 1'b0;
		end else begin
			level <= next_level;
		end
	end
endmodule

/* hce_blank_retime.sv */
// Stacked resampling stages for one line blanking signal
`timescale 1ns/1ps
module hce_blank_retime (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Blanking in and stage enables
	input wire logic blank_in,
	input wire logic resample_en,
	input wire logic extra_en,
	// Delayed blanking
	output logic blank_out
);
	import hce_pkg::*;

	logic stage_one;
	logic stage_two;
	logic next_stage_one;
	logic next_stage_two;

	always_comb begin
		next_stage_one = blank_in;
		next_stage_two = stage_one;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage_one <= 1'b0;
			stage_two <= 1'b0;
		end else begin
			stage_one <= next_stage_one;
			stage_two <= next_stage_two;
		end
	end

	// Each enabled stage adds one clock of delay
	always_comb begin
		unique case ({resample_en, extra_en})
			2'b00: blank_out = blank_in;
			2'b01: blank_out = stage_one;
			2'b10: blank_out = stage_one;
			2'b11: blank_out = stage_two;
		endcase
	end
endmodule

/* hce_regs.sv */
// Horizontal clock edge position register bank and clock shaping
//
// Overview of operation
// - Offset 0x30 holds clock A rise [5:0] reset 0, fall [13:8] reset 0x20.
// - In three-phase operation offset 0x30 places phase three, driving clocks G and H.
// - Offset 0x31 drives clock B, clock E or phase two by mode; fall resets 0x20.
// - Offset 0x32 sets last-stage clock rise and fall; fall resets 0x20.
// - Offset 0x33 sets phase one (clocks A, B) in three-phase operation only.
// - Offset 0x34 sets reset-gate clock rise and fall; fall resets 0x10.
// - Control bit 0 resamples clock A blanking, adding one stage delay.
// - Control bits 1 to 3 resample blanking for B, last stage, three-phase group.
// - Nonzero width field [7:4] widens horizontal pulses during blanking; zero disables.
// - Last-stage clock follows blanking only when control bit 9 is set.
// - Control bits 20 to 23 each add one extra blanking resample stage.
// - Output configuration codes 0x01, 0x02, 0x04, 0x10 are the only legal ones; any other code decodes as mode one.
`timescale 1ns/1ps
module hce_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register port
	input wire logic [hce_pkg::hce_addr_w-1:0] reg_addr,
	input wire logic [hce_pkg::hce_data_w-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [hce_pkg::hce_data_w-1:0] reg_rdata,
	// Timing inputs
	input wire logic [4:0] horiz_output_config,
	input wire logic line_blank,
	// Horizontal and reset gate clocks
	output logic horiz_clk_a,
	output logic horiz_clk_b,
	output logic horiz_clk_e,
	output logic horiz_clk_f,
	output logic horiz_clk_g,
	output logic horiz_clk_h,
	output logic last_stage_clk,
	output logic reset_gate_clk
);
	import hce_pkg::*;

	function automatic logic [hce_edge_reg_w-1:0] edge_reset(input logic [5:0] fall);
		edge_reset = {hce_test_rst, 2'h0, fall, 2'h0, hce_rise_rst};
	endfunction

	function automatic logic [hce_edge_reg_w-1:0] edge_write(input logic [hce_data_w-1:0] d);
		edge_write = {d[hce_test_bit], 2'h0, d[hce_fall_lsb +: hce_pos_w], 2'h0, d[hce_rise_lsb +: hce_pos_w]};
	endfunction

	function automatic logic [5:0] rise_of(input logic [hce_edge_reg_w-1:0] r);
		rise_of = r[hce_rise_lsb +: hce_pos_w];
	endfunction

	function automatic logic [5:0] fall_of(input logic [hce_edge_reg_w-1:0] r);
		fall_of = r[hce_fall_lsb +: hce_pos_w];
	endfunction

	// Widened falling edge while blanking
	function automatic logic [5:0] widen(input logic [5:0] fall, input logic [3:0] width);
		widen = 6'(fall + {2'h0, width});
	endfunction

	function automatic hce_mode_e decode_mode(input logic [4:0] cfg);
		unique case (cfg)
			hce_cfg_mode_one: decode_mode = hce_mode_one;
			hce_cfg_mode_two: decode_mode = hce_mode_two;
			hce_cfg_mode_three: decode_mode = hce_mode_three;
			hce_cfg_three_phase: decode_mode = hce_three_phase;
			default: decode_mode = hce_mode_one;
		endcase
	endfunction

	// Register state
	logic [hce_edge_reg_w-1:0] clk_a_edge;
	logic [hce_edge_reg_w-1:0] clk_b_edge;
	logic [hce_edge_reg_w-1:0] last_edge;
	logic [hce_edge_reg_w-1:0] phase_one_edge;
	logic [hce_edge_reg_w-1:0] reset_gate_edge;
	logic [hce_ctrl_reg_w-1:0] blank_ctrl;
	logic [hce_edge_reg_w-1:0] next_clk_a_edge;
	logic [hce_edge_reg_w-1:0] next_clk_b_edge;
	logic [hce_edge_reg_w-1:0] next_last_edge;
	logic [hce_edge_reg_w-1:0] next_phase_one_edge;
	logic [hce_edge_reg_w-1:0] next_reset_gate_edge;
	logic [hce_ctrl_reg_w-1:0] next_blank_ctrl;
	logic [hce_data_w-1:0] next_reg_rdata;

	always_comb begin
		next_clk_a_edge = clk_a_edge;
		next_clk_b_edge = clk_b_edge;
		next_last_edge = last_edge;
		next_phase_one_edge = phase_one_edge;
		next_reset_gate_edge = reset_gate_edge;
		next_blank_ctrl = blank_ctrl;
		if (reg_wr) begin
			unique case (reg_addr)
				hce_off_clk_a_edge: next_clk_a_edge = edge_write(reg_wdata);
				hce_off_clk_b_edge: next_clk_b_edge = edge_write(reg_wdata);
				hce_off_last_edge: next_last_edge = edge_write(reg_wdata);
				hce_off_phase_one_edge: next_phase_one_edge = edge_write(reg_wdata);
				hce_off_reset_gate_edge: next_reset_gate_edge = edge_write(reg_wdata);
				hce_off_blank_ctrl: next_blank_ctrl = reg_wdata[hce_ctrl_reg_w-1:0];
				default: ;
			endcase
		end
	end

	// Read data in the cycle after the strobe only
	always_comb begin
		next_reg_rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				hce_off_clk_a_edge: next_reg_rdata = 32'(clk_a_edge);
				hce_off_clk_b_edge: next_reg_rdata = 32'(clk_b_edge);
				hce_off_last_edge: next_reg_rdata = 32'(last_edge);
				hce_off_phase_one_edge: next_reg_rdata = 32'(phase_one_edge);
				hce_off_reset_gate_edge: next_reg_rdata = 32'(reset_gate_edge);
				hce_off_blank_ctrl: next_reg_rdata = 32'(blank_ctrl);
				default: next_reg_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			clk_a_edge <= edge_reset(hce_fall_rst);
			clk_b_edge <= edge_reset(hce_fall_rst);
			last_edge <= edge_reset(hce_fall_rst);
			phase_one_edge <= edge_reset(hce_fall_rst);
			reset_gate_edge <= edge_reset(hce_rg_fall_rst);
			blank_ctrl <= hce_ctrl_rst;
			reg_rdata <= '0;
		end else begin
			clk_a_edge <= next_clk_a_edge;
			clk_b_edge <= next_clk_b_edge;
			last_edge <= next_last_edge;
			phase_one_edge <= next_phase_one_edge;
			reset_gate_edge <= next_reset_gate_edge;
			blank_ctrl <= next_blank_ctrl;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Position counter across the pixel period
	logic [hce_pos_w-1:0] phase_pos;
	logic [hce_pos_w-1:0] next_phase_pos;

	always_comb begin
		next_phase_pos = 6'(phase_pos + 6'h01);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_pos <= '0;
		end else begin
			phase_pos <= next_phase_pos;
		end
	end

	// Control fields
	logic [3:0] pulse_width;
	logic wide_en;
	hce_mode_e mode;

	always_comb begin
		pulse_width = blank_ctrl[hce_width_lsb +: hce_width_w];
		wide_en = pulse_width != 4'h0;
		mode = decode_mode(horiz_output_config);
	end

	// Edge generators, normal and widened
	logic lvl_30;
	logic lvl_30_wide;
	logic lvl_31;
	logic lvl_31_wide;
	logic lvl_32;
	logic lvl_33;
	logic lvl_33_wide;
	logic lvl_34;

	hce_edge_gen u_gen_30 (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(clk_a_edge)), .fall_pos(fall_of(clk_a_edge)), .level(lvl_30));
	hce_edge_gen u_gen_30w (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(clk_a_edge)), .fall_pos(widen(fall_of(clk_a_edge), pulse_width)),
		.level(lvl_30_wide));
	hce_edge_gen u_gen_31 (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(clk_b_edge)), .fall_pos(fall_of(clk_b_edge)), .level(lvl_31));
	hce_edge_gen u_gen_31w (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(clk_b_edge)), .fall_pos(widen(fall_of(clk_b_edge), pulse_width)),
		.level(lvl_31_wide));
	hce_edge_gen u_gen_32 (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(last_edge)), .fall_pos(fall_of(last_edge)), .level(lvl_32));
	hce_edge_gen u_gen_33 (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(phase_one_edge)), .fall_pos(fall_of(phase_one_edge)), .level(lvl_33));
	hce_edge_gen u_gen_33w (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(phase_one_edge)), .fall_pos(widen(fall_of(phase_one_edge), pulse_width)),
		.level(lvl_33_wide));
	hce_edge_gen u_gen_34 (.ref_clk(ref_clk), .srst(srst), .phase_pos(phase_pos),
		.rise_pos(rise_of(reset_gate_edge)), .fall_pos(fall_of(reset_gate_edge)), .level(lvl_34));

	// Blanking per output group
	logic blank_a;
	logic blank_b;
	logic blank_last;
	logic blank_three;

	hce_blank_retime u_rt_a (.ref_clk(ref_clk), .srst(srst), .blank_in(line_blank),
		.resample_en(blank_ctrl[hce_resample_a_bit]), .extra_en(blank_ctrl[hce_extra_a_bit]),
		.blank_out(blank_a));
	hce_blank_retime u_rt_b (.ref_clk(ref_clk), .srst(srst), .blank_in(line_blank),
		.resample_en(blank_ctrl[hce_resample_b_bit]), .extra_en(blank_ctrl[hce_extra_b_bit]),
		.blank_out(blank_b));
	hce_blank_retime u_rt_last (.ref_clk(ref_clk), .srst(srst), .blank_in(line_blank),
		.resample_en(blank_ctrl[hce_resample_last_bit]), .extra_en(blank_ctrl[hce_extra_last_bit]),
		.blank_out(blank_last));
	hce_blank_retime u_rt_three (.ref_clk(ref_clk), .srst(srst), .blank_in(line_blank),
		.resample_en(blank_ctrl[hce_resample_three_bit]), .extra_en(blank_ctrl[hce_extra_three_bit]),
		.blank_out(blank_three));

	// Gated levels: low in blanking unless widening is on
	logic gate_30;
	logic gate_31;
	logic gate_33;
	logic gate_30_three;
	logic gate_31_three;

	always_comb begin
		gate_30 = blank_a ? (wide_en & lvl_30_wide) : lvl_30;
		gate_31 = blank_b ? (wide_en & lvl_31_wide) : lvl_31;
		gate_33 = blank_three ? (wide_en & lvl_33_wide) : lvl_33;
		gate_30_three = blank_three ? (wide_en & lvl_30_wide) : lvl_30;
		gate_31_three = blank_three ? (wide_en & lvl_31_wide) : lvl_31;
	end

	// Output routing by horizontal configuration
	logic next_clk_a;
	logic next_clk_b;
	logic next_clk_e;
	logic next_clk_f;
	logic next_clk_g;
	logic next_clk_h;
	logic next_last_clk;
	logic next_rg_clk;

	always_comb begin
		next_clk_a = gate_30;
		next_clk_b = ~gate_30;
		next_clk_e = 1'b0;
		next_clk_f = 1'b0;
		next_clk_g = 1'b0;
		next_clk_h = 1'b0;
		unique case (mode)
			hce_mode_one: begin
				next_clk_a = gate_30;
				next_clk_b = ~gate_30;
			end
			hce_mode_two: begin
				next_clk_a = gate_30;
				next_clk_b = gate_31;
			end
			hce_mode_three: begin
				next_clk_a = gate_30;
				next_clk_b = ~gate_30;
				next_clk_e = gate_31;
				next_clk_f = ~gate_31;
			end
			hce_three_phase: begin
				next_clk_a = gate_33;
				next_clk_b = gate_33;
				next_clk_e = gate_31_three;
				next_clk_f = gate_31_three;
				next_clk_g = gate_30_three;
				next_clk_h = gate_30_three;
			end
		endcase
		next_last_clk = (blank_ctrl[hce_last_blank_en_bit] && blank_last) ? 1'b0 : lvl_32;
		next_rg_clk = lvl_34;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			horiz_clk_a <= 1'b0;
			horiz_clk_b <= 1'b0;
			horiz_clk_e <= 1'b0;
			horiz_clk_f <= 1'b0;
			horiz_clk_g <= 1'b0;
			horiz_clk_h <= 1'b0;
			last_stage_clk <= 1'b0;
			reset_gate_clk <= 1'b0;
		end else begin
			horiz_clk_a <= next_clk_a;
			horiz_clk_b <= next_clk_b;
			horiz_clk_e <= next_clk_e;
			horiz_clk_f <= next_clk_f;
			horiz_clk_g <= next_clk_g;
			horiz_clk_h <= next_clk_h;
			last_stage_clk <= next_last_clk;
			reset_gate_clk <= next_rg_clk;
		end
	end
endmodule

/* hce_regs_asserts.sv */
// Port checker for the horizontal clock edge position bank
`timescale 1ns/1ps
module hce_regs_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register port
	input wire logic [hce_pkg::hce_addr_w-1:0] reg_addr,
	input wire logic [hce_pkg::hce_data_w-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [hce_pkg::hce_data_w-1:0] reg_rdata,
	// Timing inputs
	input wire logic [4:0] horiz_output_config,
	input wire logic line_blank,
	// Clocks
	input wire logic horiz_clk_a,
	input wire logic horiz_clk_b,
	input wire logic horiz_clk_e,
	input wire logic horiz_clk_f,
	input wire logic horiz_clk_g,
	input wire logic horiz_clk_h,
	input wire logic last_stage_clk,
	input wire logic reset_gate_clk
);
	import hce_pkg::*;
	logic [23:0] ctrl;
	logic [23:0] next_ctrl;
	logic [3:0] blank_cnt;
	logic [3:0] next_blank_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Shadow of the blanking control word and length of the current blank
	always_comb begin
		next_ctrl = (reg_wr && reg_addr == hce_off_blank_ctrl) ? reg_wdata[23:0] : ctrl;
		next_blank_cnt = !line_blank ? 4'h0 : (blank_cnt == 4'hf) ? blank_cnt : blank_cnt + 4'h1;
	end
	always_ff @(posedge ref_clk) begin
		ctrl <= srst ? hce_ctrl_rst : next_ctrl;
		blank_cnt <= srst ? 4'h0 : next_blank_cnt;
	end
	sequence s_rd_edge;
		reg_rd && reg_addr >= 8'h30 && reg_addr <= 8'h34;
	endsequence
	sequence s_rd_unmapped;
		reg_rd && (reg_addr < 8'h30 || reg_addr > 8'h35);
	endsequence
	sequence s_ctrl_wr_rd;
		reg_wr && reg_addr == 8'h35 ##1 reg_rd && reg_addr == 8'h35;
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (s_rd_unmapped |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_edge_mask: assert property (s_rd_edge |=> (reg_rdata & ~32'h13f3f) == '0)
		else $error("edge register unused bits not zero");
	a_ctrl_readback: assert property (s_ctrl_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & 32'hffffff))
		else $error("blanking control read back wrong");
	a_mode_one_pair: assert property ((horiz_output_config == hce_cfg_mode_one && !line_blank)[*6]
		|-> horiz_clk_b == !horiz_clk_a) else $error("clock b not inverse of a");
	a_three_phase_pairs: assert property ((horiz_output_config == hce_cfg_three_phase)[*4]
		|-> horiz_clk_a == horiz_clk_b && horiz_clk_e == horiz_clk_f && horiz_clk_g == horiz_clk_h)
		else $error("three phase pair differs");
	a_blank_low: assert property (blank_cnt >= 4'h8 && ctrl[7:4] == 4'h0
		|-> !(horiz_clk_a || horiz_clk_b || horiz_clk_e || horiz_clk_f || horiz_clk_g || horiz_clk_h))
		else $error("clock high during blank");
	a_last_blank: assert property (blank_cnt >= 4'h8 && ctrl[9] |-> !last_stage_clk)
		else $error("last stage high during blank");
endmodule
bind hce_regs hce_regs_asserts u_hce_regs_asserts (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .horiz_output_config, .line_blank, .horiz_clk_a, .horiz_clk_b, .horiz_clk_e, .horiz_clk_f,
	.horiz_clk_g, .horiz_clk_h, .last_stage_clk, .reset_gate_clk);

/* hce_sensor_model.sv */
// Sensor side model measuring period and high time of each clock
`timescale 1ns/1ps
module hce_sensor_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Horizontal, last stage and reset gate clocks
	input wire logic [7:0] clks,
	// Last full period and high time per clock
	output int period [8],
	output int high_time [8]
);
	int age [8];
	int hi [8];
	logic [7:0] prev = 8'h00;
	always @(posedge ref_clk) begin
		for (int i = 0; i < 8; i++) begin
			if (clks[i] && !prev[i]) begin
				period[i] <= age[i];
				high_time[i] <= hi[i];
				age[i] <= 1;
				hi[i] <= 1;
			end else begin
				age[i] <= age[i] + 1;
				hi[i] <= hi[i] + int'(clks[i]);
			end
		end
		prev <= srst ? 8'h00 : clks;
	end
endmodule

/* hclock_edge_position_regs_test.sv */
// Self-checking bench for the horizontal clock edge position bank
`timescale 1ns/1ps
module hclock_edge_position_regs_test;
	import hce_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [hce_addr_w-1:0] reg_addr = '0;
	logic [hce_data_w-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [hce_data_w-1:0] reg_rdata;
	logic [4:0] cfg = hce_cfg_mode_one;
	logic line_blank = 1'b0;
	wire [7:0] clks;
	int period [8];
	int high_time [8];
	int n_mismatch = 0;
	int total_checks = 0;
	int mdl [6] = '{32'h12000, 32'h12000, 32'h12000, 32'h12000, 32'h11000, 0};
	int rs [5];
	int fl [5];
	int ex [8];
	logic [4:0] codes [4] = '{hce_cfg_mode_one, hce_cfg_mode_two, hce_cfg_mode_three, hce_cfg_three_phase};
	int gidx [4] = '{0, 1, 6, 4};

	always #2 ref_clk = ~ref_clk;

	hce_regs dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .horiz_output_config(cfg),
		.line_blank, .horiz_clk_a(clks[0]), .horiz_clk_b(clks[1]), .horiz_clk_e(clks[2]), .horiz_clk_f(clks[3]),
		.horiz_clk_g(clks[4]), .horiz_clk_h(clks[5]), .last_stage_clk(clks[6]), .reset_gate_clk(clks[7]));
	hce_sensor_model u_sensor (.ref_clk, .srst, .clks, .period, .high_time);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		if (a >= 8'h30 && a <= 8'h34) begin
			mdl[a - 8'h30] = d & 32'h13f3f;
		end else if (a == hce_off_blank_ctrl) begin
			mdl[5] = d & 32'hffffff;
		end
	endtask
	// Read with one idle edge so the data is taken in its only valid cycle
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk($sformatf("reg %h", a), reg_rdata, (a >= 8'h30 && a <= 8'h35) ? 32'(mdl[a - 8'h30]) : 32'h0);
	endtask
	task automatic wrc(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		rd(a);
	endtask
	task automatic set_edge(input int k, input int r, input int f);
		rs[k] = r;
		fl[k] = f;
		wrc(8'h30 + 8'(k), 32'h10000 | 32'(f << 8) | 32'(r));
	endtask
	function automatic int hi(input int k);
		return (fl[k] - rs[k]) & 63;
	endfunction
	task automatic wait_level(input int idx, input logic v, output int n);
		n = 0;
		while (clks[idx] !== v) begin
			@(posedge ref_clk);
			n++;
			if (n > 200) begin
				n_mismatch++;
				wrap_up();
			end
		end
	endtask
	// Cycles from blank onset at a clock's rising edge until it is forced low
	task automatic lag(input int idx, output int n);
		repeat (8) @(posedge ref_clk);
		wait_level(idx, 1'b0, n);
		wait_level(idx, 1'b1, n);
		line_blank <= 1'b1;
		wait_level(idx, 1'b0, n);
		line_blank <= 1'b0;
	endtask

	initial begin
		int n;
		int base;
		int w;
		logic [7:0] a;
		logic [31:0] d;
		void'($urandom(16294));
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		for (int k = 8'h2f; k <= 8'h36; k++) begin
			rd(8'(k));
		end
		repeat (16) begin
			a = 8'h30 + 8'($urandom % 7);
			d = $urandom;
			d = (a == hce_off_blank_ctrl) ? (d & 32'hfff002ff) : (d | 32'h10000);
			wrc(a, d);
		end
		wrc(8'h80, 32'h13f3f);
		wrc(hce_off_blank_ctrl, 32'h0);
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 5; k++) begin
				w = $urandom % 64;
				set_edge(k, w, (w + 1 + $urandom % 63) % 64);
			end
			@(posedge ref_clk);
			cfg <= codes[m];
			repeat (200) @(posedge ref_clk);
			ex = '{-1, -1, -1, -1, -1, -1, hi(2), hi(4)};
			ex[0] = hi(m == 3 ? 3 : 0);
			ex[1] = m == 1 ? hi(1) : m == 3 ? hi(3) : 64 - hi(0);
			if (m >= 2) begin
				ex[2] = hi(1);
				ex[3] = m == 3 ? hi(1) : 64 - hi(1);
			end
			if (m == 3) begin
				ex[4] = hi(0);
				ex[5] = hi(0);
			end
			for (int i = 0; i < 8; i++) begin
				if (ex[i] >= 0) begin
					chk($sformatf("high time %0d", i), high_time[i], ex[i]);
				end
			end
			chk("rg period", period[7], 64);
		end
		set_edge(0, 0, 16);
		set_edge(2, 0, 16);
		w = 1 + $urandom % 15;
		wrc(hce_off_blank_ctrl, 32'(w << 4));
		@(posedge ref_clk);
		cfg <= hce_cfg_mode_one;
		line_blank <= 1'b1;
		repeat (200) @(posedge ref_clk);
		chk("wide a high", high_time[0], 16 + w);
		chk("last unblanked", high_time[6], 16);
		line_blank <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			set_edge(k, 0, 63);
		end
		for (int g = 0; g < 4; g++) begin
			for (int dl = 0; dl < 3; dl++) begin
				wrc(hce_off_blank_ctrl, 32'h200 | (dl > 0 ? 32'h1 << g : 0) | (dl > 1 ? 32'h1 << (20 + g) : 0));
				@(posedge ref_clk);
				cfg <= codes[g == 3 ? 3 : g == 1 ? 1 : 0];
				lag(gidx[g], n);
				if (dl == 0) begin
					base = n;
				end else begin
					chk("blank lag", 32'(n - base), 32'(dl));
				end
			end
		end
		@(posedge ref_clk);
		line_blank <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk("last blanked", 32'(clks[6]), 32'h0);
		line_blank <= 1'b0;
		wrap_up();
	end
endmodule
